// *** verilog/ecsm_pkg.sv ***
// constants for the echo canceller state monitor register bank
package ecsm_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CANCEL_MON = 8'h2d;
  localparam logic [7:0] IDX_CTRL_MON = 8'h2e;
  localparam logic [7:0] IDX_TS_MON_CTRL = 8'h30;
  localparam logic [7:0] IDX_FLEX_CFG = 8'h31;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h32;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h33;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  // widths
  localparam int MON_W = 8;
  localparam int FLAG_W = 16;
  localparam int CH_W = 5;
  localparam int SEL_W = 3;
  localparam int IRQ_W = 2;
  localparam int PIN_N = 2;
  // canceller_state_monitor_b bit positions
  localparam int BIT_LOSS_BYPASS = 7;
  localparam int BIT_DOUBLE_TALK = 6;
  localparam int BIT_FAST_CONV = 5;
  localparam int BIT_STAB_PROT = 4;
  localparam int BIT_TONE_UNPROT = 3;
  localparam int BIT_TONE_LVL2 = 2;
  localparam int BIT_TONE_LVL1 = 1;
  localparam int BIT_IDLE = 0;
  // control_input_state_monitor bit positions
  localparam int BIT_CAS_DIS = 7;
  localparam int BIT_CC_DIS = 6;
  localparam int BIT_CC_FLEX = 5;
  localparam int BIT_SER_DIS = 4;
  localparam int BIT_SER_NLP_OFF = 3;
  localparam int BIT_SER_FREEZE = 2;
  localparam int BIT_SER_CONV_OFF = 1;
  localparam int BIT_SER_FLEX = 0;
  // flexible_monitor_config fields: pin n select at 4n, enable at 4n+3
  localparam int FLEX_FIELD_STRIDE = 4;
  localparam int FLEX_EN_OFS = 3;
  // interrupt status bits
  localparam int IRQ_CANCEL_CHG = 0;
  localparam int IRQ_CTRL_CHG = 1;
  // reset values
  localparam logic [MON_W-1:0] MON_RST = 8'h00;
  localparam logic [CH_W-1:0] CH_RST = 5'h00;
  localparam logic [MON_W-1:0] FLEX_CFG_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
endpackage : ecsm_pkg

// *** verilog/ecsm_sync.sv ***
// two flip-flop synchroniser for the monitor flag inputs
`timescale 1ns/10ps
module ecsm_sync
  import ecsm_pkg::*;
#(
  parameter int W = FLAG_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_dout;

  always_comb begin
    next_stage1 = din;
    next_dout = stage1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= next_stage1;
      dout <= next_dout;
    end
  end
endmodule : ecsm_sync

// *** verilog/ecsm_top.sv ***
// echo canceller state monitor registers with AHB-Lite slave
// What this block does
// - bit 7 of canceller monitor set while subtractor bypassed by echo return loss.
// - bit 6 of canceller monitor set during true double talk.
// - bit 5 of canceller monitor set while fast convergence mode runs.
// - bit 4 of canceller monitor set while stability protection is active.
// - bit 3 set when 2010 Hz tone seen without speech protection.
// - bit 1 set when 2010 Hz protection first level bypasses canceller.
// - bit 2 set when 2010 Hz protection second level resets coefficients.
// - bit 0 of canceller monitor set while idle channel detected.
// - any canceller monitor bit can drive either flexible monitor pin.
// - bit 7 of control monitor set when signalling evaluation disables channel.
// - bit 6 of control monitor set while channel control disable bit active.
// - bit 5 of control monitor set while channel control flex bit active.
// - bits 4..0 of control monitor mirror the five serial control inputs.
// - monitors show the channel chosen in the channel-select field.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module ecsm_top
  import ecsm_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic LOSS_BYPASS_FLAG,
  input wire logic DOUBLE_TALK_FLAG,
  input wire logic FAST_CONVERGE_FLAG,
  input wire logic STABILITY_PROTECT_FLAG,
  input wire logic TONE_UNPROTECTED_FLAG,
  input wire logic TONE_LEVEL_TWO_FLAG,
  input wire logic TONE_LEVEL_ONE_FLAG,
  input wire logic IDLE_CHANNEL_FLAG,
  input wire logic CAS_DISABLE_FLAG,
  input wire logic CHAN_CTRL_DISABLE_FLAG,
  input wire logic CHAN_CTRL_FLEX_FLAG,
  input wire logic SERIAL_DISABLE_FLAG,
  input wire logic SERIAL_NONLINEAR_OFF_FLAG,
  input wire logic SERIAL_FREEZE_FLAG,
  input wire logic SERIAL_CONVERGE_OFF_FLAG,
  input wire logic SERIAL_FLEXIBLE_CTRL_FLAG,
  output logic [CH_W-1:0] MONITORED_CHANNEL_SELECT,
  output logic FLEXIBLE_MONITOR_PIN_A,
  output logic FLEXIBLE_MONITOR_PIN_B,
  output logic IRQ
);

  // true when a word index selects the given register
  function automatic logic reg_hit(input logic [7:0] idx, input logic [7:0] target);
    reg_hit = (idx == target);
  endfunction : reg_hit

  // flag inputs come from the datapath pins and are synchronised first
  logic [FLAG_W-1:0] flag_raw;
  logic [FLAG_W-1:0] flag_sync;

  assign flag_raw = {
    LOSS_BYPASS_FLAG,
    DOUBLE_TALK_FLAG,
    FAST_CONVERGE_FLAG,
    STABILITY_PROTECT_FLAG,
    TONE_UNPROTECTED_FLAG,
    TONE_LEVEL_TWO_FLAG,
    TONE_LEVEL_ONE_FLAG,
    IDLE_CHANNEL_FLAG,
    CAS_DISABLE_FLAG,
    CHAN_CTRL_DISABLE_FLAG,
    CHAN_CTRL_FLEX_FLAG,
    SERIAL_DISABLE_FLAG,
    SERIAL_NONLINEAR_OFF_FLAG,
    SERIAL_FREEZE_FLAG,
    SERIAL_CONVERGE_OFF_FLAG,
    SERIAL_FLEXIBLE_CTRL_FLAG
  };

  ecsm_sync #(
    .W(FLAG_W)
  ) u_sync (
    .clk(CLK),
    .nrst(NRST),
    .din(flag_raw),
    .dout(flag_sync)
  );

  // upper byte feeds the canceller monitor, lower byte the control monitor
  logic [MON_W-1:0] cancel_sync;
  logic [MON_W-1:0] ctrl_sync;

  assign cancel_sync = flag_sync[FLAG_W-1:MON_W];
  assign ctrl_sync = flag_sync[MON_W-1:0];

  // state registers
  logic [MON_W-1:0] cancel_mon;
  logic [MON_W-1:0] ctrl_mon;
  logic [CH_W-1:0] ch_sel;
  logic [MON_W-1:0] flex_cfg;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic wr_pend;
  logic [7:0] wr_idx;
  logic [PIN_N-1:0] flex_pin;

  logic [MON_W-1:0] next_cancel_mon;
  logic [MON_W-1:0] next_ctrl_mon;
  logic [CH_W-1:0] next_ch_sel;
  logic [MON_W-1:0] next_flex_cfg;
  logic [IRQ_W-1:0] next_irq_stat;
  logic [IRQ_W-1:0] next_irq_mask;
  logic next_wr_pend;
  logic [7:0] next_wr_idx;
  logic [31:0] next_hrdata;
  logic next_hreadyout;
  logic next_hresp;
  logic [PIN_N-1:0] next_flex_pin;
  logic [IRQ_W-1:0] irq_pend;
  logic next_irq;

  // address phase decode
  logic addr_valid;
  logic [7:0] addr_idx;
  logic rd_take;

  assign addr_valid = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
  assign addr_idx = HADDR[IDX_MSB:IDX_LSB];
  assign rd_take = addr_valid && !HWRITE;

  // data phase write strobes; the monitor registers have none
  logic wr_ch_sel;
  logic wr_flex_cfg;
  logic wr_irq_mask;
  logic wr_irq_clr;

  assign wr_ch_sel = wr_pend && reg_hit(wr_idx, IDX_TS_MON_CTRL);
  assign wr_flex_cfg = wr_pend && reg_hit(wr_idx, IDX_FLEX_CFG);
  assign wr_irq_mask = wr_pend && reg_hit(wr_idx, IDX_IRQ_MASK);
  assign wr_irq_clr = wr_pend && reg_hit(wr_idx, IDX_IRQ_STAT);

  // monitor capture from the synchronised flags of the selected channel
  always_comb begin
    next_cancel_mon = MON_RST;
    next_ctrl_mon = MON_RST;
    next_cancel_mon[BIT_LOSS_BYPASS] = cancel_sync[BIT_LOSS_BYPASS];
    next_cancel_mon[BIT_DOUBLE_TALK] = cancel_sync[BIT_DOUBLE_TALK];
    next_cancel_mon[BIT_FAST_CONV] = cancel_sync[BIT_FAST_CONV];
    next_cancel_mon[BIT_STAB_PROT] = cancel_sync[BIT_STAB_PROT];
    next_cancel_mon[BIT_TONE_UNPROT] = cancel_sync[BIT_TONE_UNPROT];
    next_cancel_mon[BIT_TONE_LVL2] = cancel_sync[BIT_TONE_LVL2];
    next_cancel_mon[BIT_TONE_LVL1] = cancel_sync[BIT_TONE_LVL1];
    next_cancel_mon[BIT_IDLE] = cancel_sync[BIT_IDLE];
    next_ctrl_mon[BIT_CAS_DIS] = ctrl_sync[BIT_CAS_DIS];
    next_ctrl_mon[BIT_CC_DIS] = ctrl_sync[BIT_CC_DIS];
    next_ctrl_mon[BIT_CC_FLEX] = ctrl_sync[BIT_CC_FLEX];
    next_ctrl_mon[BIT_SER_DIS] = ctrl_sync[BIT_SER_DIS];
    next_ctrl_mon[BIT_SER_NLP_OFF] = ctrl_sync[BIT_SER_NLP_OFF];
    next_ctrl_mon[BIT_SER_FREEZE] = ctrl_sync[BIT_SER_FREEZE];
    next_ctrl_mon[BIT_SER_CONV_OFF] = ctrl_sync[BIT_SER_CONV_OFF];
    next_ctrl_mon[BIT_SER_FLEX] = ctrl_sync[BIT_SER_FLEX];
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cancel_mon <= MON_RST;
      ctrl_mon <= MON_RST;
    end else begin
      cancel_mon <= next_cancel_mon;
      ctrl_mon <= next_ctrl_mon;
    end
  end

  // a monitor register takes a new value at the next edge
  logic cancel_chg;
  logic ctrl_chg;

  assign cancel_chg = (next_cancel_mon != cancel_mon);
  assign ctrl_chg = (next_ctrl_mon != ctrl_mon);

  // bus write path and interrupt flags
  always_comb begin
    next_ch_sel = ch_sel;
    next_flex_cfg = flex_cfg;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_wr_pend = addr_valid && HWRITE;
    next_wr_idx = addr_valid ? addr_idx : wr_idx;
    if (wr_ch_sel) begin
      next_ch_sel = HWDATA[CH_W-1:0];
    end
    if (wr_flex_cfg) begin
      next_flex_cfg = HWDATA[MON_W-1:0];
    end
    if (wr_irq_mask) begin
      next_irq_mask = HWDATA[IRQ_W-1:0];
    end
    if (wr_irq_clr) begin
      next_irq_stat = irq_stat & ~HWDATA[IRQ_W-1:0];
    end
    // writes to the two monitor registers fall through unused
    // a change set in the same cycle as a clear wins
    if (cancel_chg) begin
      next_irq_stat[IRQ_CANCEL_CHG] = 1'b1;
    end
    if (ctrl_chg) begin
      next_irq_stat[IRQ_CTRL_CHG] = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ch_sel <= CH_RST;
      flex_cfg <= FLEX_CFG_RST;
      irq_mask <= IRQ_RST;
      irq_stat <= IRQ_RST;
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
    end else begin
      ch_sel <= next_ch_sel;
      flex_cfg <= next_flex_cfg;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
      wr_pend <= next_wr_pend;
      wr_idx <= next_wr_idx;
    end
  end

  // read data is prepared in the address phase from the next values of the writable registers,
  // so a read right after a write already sees the written value
  always_comb begin
    next_hrdata = 32'h0000_0000;
    next_hreadyout = 1'b1;
    next_hresp = HRESP_OKAY;
    if (rd_take) begin
      if (reg_hit(addr_idx, IDX_CANCEL_MON)) begin
        next_hrdata[MON_W-1:0] = cancel_mon;
      end
      if (reg_hit(addr_idx, IDX_CTRL_MON)) begin
        next_hrdata[MON_W-1:0] = ctrl_mon;
      end
      if (reg_hit(addr_idx, IDX_TS_MON_CTRL)) begin
        next_hrdata[CH_W-1:0] = next_ch_sel;
      end
      if (reg_hit(addr_idx, IDX_FLEX_CFG)) begin
        next_hrdata[MON_W-1:0] = next_flex_cfg;
      end
      if (reg_hit(addr_idx, IDX_IRQ_STAT)) begin
        next_hrdata[IRQ_W-1:0] = next_irq_stat;
      end
      if (reg_hit(addr_idx, IDX_IRQ_MASK)) begin
        next_hrdata[IRQ_W-1:0] = next_irq_mask;
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= HRESP_OKAY;
    end else begin
      HRDATA <= next_hrdata;
      HREADYOUT <= next_hreadyout;
      HRESP <= next_hresp;
    end
  end

  // flexible monitor pins: each picks one canceller monitor bit
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_flex
      logic [SEL_W-1:0] sel;
      logic en;
      assign sel = flex_cfg[gi*FLEX_FIELD_STRIDE +: SEL_W];
      assign en = flex_cfg[gi*FLEX_FIELD_STRIDE + FLEX_EN_OFS];
      assign next_flex_pin[gi] = en && next_cancel_mon[sel];
    end
  endgenerate

  assign irq_pend = next_irq_stat & next_irq_mask;
  assign next_irq = |irq_pend;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      flex_pin <= '0;
      MONITORED_CHANNEL_SELECT <= CH_RST;
      IRQ <= 1'b0;
    end else begin
      flex_pin <= next_flex_pin;
      MONITORED_CHANNEL_SELECT <= next_ch_sel;
      IRQ <= next_irq;
    end
  end

  // pins show the registered flexible selection
  assign FLEXIBLE_MONITOR_PIN_A = flex_pin[0];
  assign FLEXIBLE_MONITOR_PIN_B = flex_pin[1];

endmodule : ecsm_top

// *** bench/ecsm_monitor.sv ***
// checker for the state monitor read paths and channel select
`timescale 1ns/10ps
module ecsm_monitor
  import ecsm_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic LOSS_BYPASS_FLAG,
  input wire logic DOUBLE_TALK_FLAG,
  input wire logic FAST_CONVERGE_FLAG,
  input wire logic STABILITY_PROTECT_FLAG,
  input wire logic TONE_UNPROTECTED_FLAG,
  input wire logic TONE_LEVEL_TWO_FLAG,
  input wire logic TONE_LEVEL_ONE_FLAG,
  input wire logic IDLE_CHANNEL_FLAG,
  input wire logic CAS_DISABLE_FLAG,
  input wire logic CHAN_CTRL_DISABLE_FLAG,
  input wire logic CHAN_CTRL_FLEX_FLAG,
  input wire logic SERIAL_DISABLE_FLAG,
  input wire logic SERIAL_NONLINEAR_OFF_FLAG,
  input wire logic SERIAL_FREEZE_FLAG,
  input wire logic SERIAL_CONVERGE_OFF_FLAG,
  input wire logic SERIAL_FLEXIBLE_CTRL_FLAG,
  input wire logic [CH_W-1:0] MONITORED_CHANNEL_SELECT
);
  wire logic take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
  wire logic [7:0] idx = HADDR[IDX_MSB:IDX_LSB];
  wire logic wr_ch = take && HWRITE && (idx == IDX_TS_MON_CTRL);
  wire logic [7:0] can_f = {LOSS_BYPASS_FLAG, DOUBLE_TALK_FLAG, FAST_CONVERGE_FLAG,
    STABILITY_PROTECT_FLAG, TONE_UNPROTECTED_FLAG, TONE_LEVEL_TWO_FLAG, TONE_LEVEL_ONE_FLAG,
    IDLE_CHANNEL_FLAG};
  wire logic [7:0] ctl_f = {CAS_DISABLE_FLAG, CHAN_CTRL_DISABLE_FLAG, CHAN_CTRL_FLEX_FLAG,
    SERIAL_DISABLE_FLAG, SERIAL_NONLINEAR_OFF_FLAG, SERIAL_FREEZE_FLAG,
    SERIAL_CONVERGE_OFF_FLAG, SERIAL_FLEXIBLE_CTRL_FLAG};
  logic [15:0] prev_f;
  logic [2:0] stab;
  // reads judged only once the flags have settled through the synchroniser
  wire logic ok_c = take && !HWRITE && (idx == IDX_CANCEL_MON) && (stab >= 3'h4);
  wire logic ok_t = take && !HWRITE && (idx == IDX_CTRL_MON) && (stab >= 3'h4);
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      prev_f <= 16'h0000;
      stab <= 3'h0;
    end else begin
      prev_f <= {can_f, ctl_f};
      stab <= ({can_f, ctl_f} != prev_f) ? 3'h0 : ((stab == 3'h7) ? stab : stab + 3'h1);
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  a_loss_talk: assert property (ok_c |=> HRDATA[7:6] == $past(can_f[7:6]))
    else $error("loss bypass or double talk bit wrong");
  a_conv_prot: assert property (ok_c |=> HRDATA[5:4] == $past(can_f[5:4]))
    else $error("convergence or stability bit wrong");
  a_tone_bits: assert property (ok_c ##1 1'b1 |-> HRDATA[3:1] == $past(can_f[3:1]))
    else $error("tone protection bits wrong");
  a_idle_bit: assert property (ok_c |=> HRDATA[0] == $past(can_f[0]))
    else $error("idle channel bit wrong");
  a_ctrl_iface: assert property (ok_t |=> HRDATA[7:5] == $past(ctl_f[7:5]))
    else $error("signalling or channel control bits wrong");
  a_serial_mirror: assert property (ok_t |=> HRDATA[4:0] == $past(ctl_f[4:0]))
    else $error("serial control mirror wrong");
  a_chan_load: assert property (wr_ch |=> ##1 MONITORED_CHANNEL_SELECT == $past(HWDATA[4:0]))
    else $error("channel select not loaded");
  a_chan_hold: assert property (!wr_ch ##1 1'b1 |=> $stable(MONITORED_CHANNEL_SELECT))
    else $error("channel select moved without write");
  c_read_can: cover property (ok_c);
  c_read_ctl: cover property (ok_t);
  c_write_ch: cover property (wr_ch);
endmodule : ecsm_monitor

bind ecsm_top ecsm_monitor u_mon (.*);

// *** bench/ecsm_tb_top.sv ***
// self-checking bench for the echo canceller state monitor
`timescale 1ns/10ps
module ecsm_tb_top
  import ecsm_pkg::*;
;
  logic CLK, NRST, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, IRQ;
  logic FLEXIBLE_MONITOR_PIN_A, FLEXIBLE_MONITOR_PIN_B;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic [CH_W-1:0] MONITORED_CHANNEL_SELECT;
  logic [15:0] fl;
  int n_fail, num_checks;
  assign HREADY = HREADYOUT;
  ecsm_top uut (.*, .LOSS_BYPASS_FLAG(fl[15]), .DOUBLE_TALK_FLAG(fl[14]),
    .FAST_CONVERGE_FLAG(fl[13]), .STABILITY_PROTECT_FLAG(fl[12]),
    .TONE_UNPROTECTED_FLAG(fl[11]), .TONE_LEVEL_TWO_FLAG(fl[10]),
    .TONE_LEVEL_ONE_FLAG(fl[9]), .IDLE_CHANNEL_FLAG(fl[8]), .CAS_DISABLE_FLAG(fl[7]),
    .CHAN_CTRL_DISABLE_FLAG(fl[6]), .CHAN_CTRL_FLEX_FLAG(fl[5]),
    .SERIAL_DISABLE_FLAG(fl[4]), .SERIAL_NONLINEAR_OFF_FLAG(fl[3]),
    .SERIAL_FREEZE_FLAG(fl[2]), .SERIAL_CONVERGE_OFF_FLAG(fl[1]),
    .SERIAL_FLEXIBLE_CTRL_FLAG(fl[0]));
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge CLK);
  endtask : wt
  // single word transfer; holds each phase until ready is sampled high
  task automatic bus(input logic wr, input logic [7:0] ix, input logic [31:0] wd);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= HTRANS_NONSEQ;
    HWRITE <= wr;
    HADDR <= {22'h0, ix, 2'h0};
    do @(posedge CLK); while (HREADY !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge CLK); while (HREADY !== 1'b1);
    rd = HRDATA;
  endtask : bus
  task automatic setf(input logic [15:0] v);
    fl <= v;
    wt(6);
  endtask : setf
  task automatic t_reset_vals;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, IDX_TS_MON_CTRL + 8'(i), 32'h0);
      chk("own reg reset", rd, 32'h0);
      chk("resp okay", {31'h0, HRESP}, {31'h0, HRESP_OKAY});
    end
  endtask : t_reset_vals
  task automatic t_flags;
    for (int i = 0; i < 17; i++) begin
      setf((i < 16) ? (16'h1 << i) : 16'h5aa5);
      bus(1'b0, IDX_CANCEL_MON, 32'h0);
      chk("cancel mon", rd, {24'h0, fl[15:8]});
      bus(1'b0, IDX_CTRL_MON, 32'h0);
      chk("ctrl mon", rd, {24'h0, fl[7:0]});
    end
  endtask : t_flags
  task automatic t_ro;
    setf(16'h3c96);
    bus(1'b1, IDX_CANCEL_MON, 32'hffffffff);
    bus(1'b0, IDX_CANCEL_MON, 32'h0);
    chk("cancel after write", rd, 32'h3c);
    bus(1'b1, IDX_CTRL_MON, 32'h0);
    bus(1'b0, IDX_CTRL_MON, 32'h0);
    chk("ctrl after write", rd, 32'h96);
    bus(1'b0, 8'h3f, 32'h0);
    chk("unmapped read", rd, 32'h0);
  endtask : t_ro
  task automatic t_chan;
    bus(1'b1, IDX_TS_MON_CTRL, 32'hffffffff);
    bus(1'b0, IDX_TS_MON_CTRL, 32'h0);
    chk("chan reg", rd, 32'h1f);
    chk("chan pins", {27'h0, MONITORED_CHANNEL_SELECT}, 32'h1f);
    bus(1'b1, IDX_TS_MON_CTRL, 32'h0a);
    wt(1);
    chk("chan pins", {27'h0, MONITORED_CHANNEL_SELECT}, 32'h0a);
  endtask : t_chan
  task automatic t_flex;
    for (int s = 0; s < 8; s++) begin
      setf({8'h1 << s, 8'h00});
      bus(1'b1, IDX_FLEX_CFG, {24'h0, 1'b1, 3'(7 - s), 1'b1, 3'(s)});
      wt(3);
      chk("pin a", {31'h0, FLEXIBLE_MONITOR_PIN_A}, 32'h1);
      chk("pin b", {31'h0, FLEXIBLE_MONITOR_PIN_B}, 32'h0);
      bus(1'b1, IDX_FLEX_CFG, {24'h0, 1'b1, 3'(s), 1'b0, 3'(s)});
      wt(3);
      chk("pin a off", {31'h0, FLEXIBLE_MONITOR_PIN_A}, 32'h0);
      chk("pin b", {31'h0, FLEXIBLE_MONITOR_PIN_B}, 32'h1);
    end
  endtask : t_flex
  task automatic t_irq;
    bus(1'b1, IDX_IRQ_STAT, 32'h3);
    bus(1'b0, IDX_IRQ_STAT, 32'h0);
    chk("status cleared", rd, 32'h0);
    setf(fl ^ 16'h0100);
    bus(1'b0, IDX_IRQ_STAT, 32'h0);
    chk("status cancel", rd, 32'h1);
    chk("irq masked", {31'h0, IRQ}, 32'h0);
    bus(1'b1, IDX_IRQ_MASK, 32'h3);
    wt(2);
    chk("irq on", {31'h0, IRQ}, 32'h1);
    bus(1'b1, IDX_IRQ_STAT, 32'h1);
    wt(2);
    chk("irq cleared", {31'h0, IRQ}, 32'h0);
    setf(fl ^ 16'h0001);
    bus(1'b0, IDX_IRQ_STAT, 32'h0);
    chk("status ctrl", rd, 32'h2);
    chk("irq ctrl", {31'h0, IRQ}, 32'h1);
  endtask : t_irq
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    NRST = 1'b0;
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    fl = 16'h0000;
    n_fail = 0;
    num_checks = 0;
    repeat (3) @(posedge CLK);
    NRST <= 1'b1;
    t_reset_vals;
    t_flags;
    t_ro;
    t_chan;
    t_flex;
    t_irq;
    tally_and_finish;
  end
  initial begin
    #50000;
    n_fail++;
    tally_and_finish;
  end
endmodule : ecsm_tb_top
